// [design/esp_buf.sv]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module esp_buf #(
	parameter int W = 17
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0] mem_r [2];
	logic         wr_ptr_r;
	logic         rd_ptr_r;
	logic [1:0]   cnt_r;
	logic         push;
	logic         pop;

	assign in_ready  = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data  = mem_r[rd_ptr_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			cnt_r    <= 2'h0;
		end
		else
		begin
			wr_ptr_r <= wr_ptr_r ^ push;
			rd_ptr_r <= rd_ptr_r ^ pop;
			cnt_r    <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem_r[wr_ptr_r] <= in_data;
	end
endmodule

// [design/esp_link.sv]
// Serial clock domain shifter of the encoder serial port
`timescale 1ns/1ns
module esp_link (
	// Reset
	input  wire logic resetn,
	// Serial pins
	input  wire logic sck,
	input  wire logic ss_n,
	input  wire logic mosi,
	output logic      miso,
	output logic      miso_oe,
	// Core side
	esp_link_if.link  lk
);
	logic        armed_r;
	logic [15:0] shift_r;
	logic [4:0]  count_r;
	logic [3:0]  rcnt_r;

	// ----------------------------------------
	// Frame start marker, set while deselected
	// ----------------------------------------
	always_ff @(negedge sck or posedge ss_n or negedge resetn)
	begin
		if (!resetn)
			armed_r <= 1'b1;
		else if (ss_n)
			armed_r <= 1'b1;
		else
			armed_r <= 1'b0;
	end

	// ----------------------------------------
	// Receive on falling edges
	// ----------------------------------------
	always_ff @(negedge sck or negedge resetn)
	begin
		if (!resetn)
		begin
			shift_r <= esp_pkg::WORD_ZERO;
			count_r <= '0;
		end
		else if (!ss_n)
		begin
			if (armed_r)
			begin
				shift_r <= {esp_pkg::WORD_ZERO[14:0], mosi};
				count_r <= esp_pkg::CNT_ONE;
			end
			else
			begin
				shift_r <= {shift_r[14:0], mosi};
				if (count_r != esp_pkg::CNT_SAT)
					count_r <= count_r + esp_pkg::CNT_ONE;
			end
		end
	end

	// ----------------------------------------
	// Transmit on rising edges
	// ----------------------------------------
	always_ff @(posedge sck or posedge ss_n or negedge resetn)
	begin
		if (!resetn)
		begin
			rcnt_r  <= '0;
			miso    <= 1'b0;
			miso_oe <= 1'b0;
		end
		else if (ss_n)
		begin
			rcnt_r  <= '0;
			miso    <= 1'b0;
			miso_oe <= 1'b0;
		end
		else
		begin
			rcnt_r  <= rcnt_r + 4'h1;
			miso    <= lk.tx_word[~rcnt_r];
			miso_oe <= lk.oe_allow;
		end
	end

	assign lk.rx_word  = shift_r;
	assign lk.rx_count = count_r;
endmodule

// [design/esp_link_if.sv]
// Signals between the link-side shifter and the core
`timescale 1ns/1ns
interface esp_link_if;
	logic [15:0] rx_word;
	logic [4:0]  rx_count;
	logic [15:0] tx_word;
	logic        oe_allow;

	modport link (output rx_word, output rx_count, input tx_word, input oe_allow);
	modport core (input rx_word, input rx_count, output tx_word, output oe_allow);
endinterface

// [design/esp_pkg.sv]
// Constants, types and helpers shared by the encoder serial port
package esp_pkg;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int         FRAME_BITS = 16;
	localparam int         DATA_BITS  = 14;
	localparam int         CNT_W      = 5;
	localparam int         BIT_RW     = 15;
	localparam logic [4:0] FRAME_LEN  = 5'h10;
	localparam logic [4:0] CNT_SAT    = 5'h11;
	localparam logic [4:0] CNT_ONE    = 5'h01;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [13:0] DATA_ZERO = 14'h0000;

	// ----------------------------------------
	// Command addresses
	// ----------------------------------------
	localparam logic [13:0] ADDR_NOP      = 14'h0000;
	localparam logic [13:0] ADDR_CLR_ERR  = 14'h3380;
	localparam logic [13:0] ADDR_SOFT_RST = 14'h3C00;

	// ----------------------------------------
	// Wire mode capture delay after reset
	// ----------------------------------------
	localparam logic [1:0] CAP_DELAY = 2'h3;
	localparam logic [1:0] CAP_LAST  = 2'h1;
	localparam logic [1:0] CAP_DONE  = 2'h0;

	// ----------------------------------------
	// Decoder states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_CMD  = 3'h1,
		ST_DATA = 3'h2,
		ST_READ = 3'h4
	} esp_state_e;

	// Reply word: data, error flag, even parity last
	function automatic logic [15:0] esp_reply(input logic [13:0] d, input logic ef);
		esp_reply = {d, ef, ^{d, ef}};
	endfunction

endpackage

// [design/esp_port.sv]
// Contract
// - Serial port acts only while slave select is low.
// - Data input sampled on every falling serial clock edge.
// - Data output updated on every rising serial clock edge.
// - Wire width select captured after power-on reset or software reset only.
// - Width select low means three-wire, high means four-wire operation.
// - Device is slave only; master supplies serial clock and select.
// - Answer to a command comes out in the following frame.
// - Frames shift most significant bit first in both directions.
// - Every access shifts a word out while one shifts in; in three-wire mode miso_oe stays low except in the frame after a read.
// - Frame holds fourteen data bits, error flag, even parity last.
// - Sticky error flag set on parity, command or clock count faults.
// - All-zero frame is a no-op answered with zero when error-free.
`timescale 1ns/1ns
module esp_port (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Serial pins
	input  wire logic        sck,
	input  wire logic        ss_n,
	input  wire logic        mosi,
	output logic             miso,
	output logic             miso_oe,
	// Strap
	input  wire logic        wire_mode,
	// Register access
	output logic             reg_req,
	output logic             reg_write,
	output logic [13:0]      reg_addr,
	output logic [13:0]      reg_wdata,
	input  wire logic [13:0] reg_rdata,
	// Status
	output logic             soft_reset,
	output logic             transfer_error_flag,
	output logic             four_wire_mode
);
	esp_link_if lk ();

	logic                ss_meta_r;
	logic                ss_sync_r;
	logic                ss_prev_r;
	logic                wm_meta_r;
	logic                wm_sync_r;
	logic [1:0]          cap_cnt_r;
	logic                four_wire_r;
	logic                hold_valid_r;
	logic [16:0]         hold_r;
	logic                overrun;
	logic                ss_rise;
	logic                buf_in_ready;
	logic                buf_out_valid;
	logic [16:0]         buf_out;
	logic                pop;
	esp_pkg::esp_state_e state_r;
	esp_pkg::esp_state_e state_nxt;
	logic [15:0]         f;
	logic [13:0]         addr;
	logic                good;
	logic                bad;
	logic                is_cmd;
	logic                is_data;
	logic                nop;
	logic                clr;
	logic                rd;
	logic                wr_cmd;
	logic                wrong;
	logic                ef_r;
	logic [13:0]         cmd_addr_r;
	logic [15:0]         reply_r;
	logic                oe_allow_r;
	logic                rd_pend_r;
	logic                reg_req_r;
	logic                reg_write_r;
	logic [13:0]         reg_addr_r;
	logic [13:0]         reg_wdata_r;
	logic                soft_reset_r;

	// ----------------------------------------
	// Link side shifter
	// ----------------------------------------
	esp_link u_link (
		.resetn  (resetn),
		.sck     (sck),
		.ss_n    (ss_n),
		.mosi    (mosi),
		.miso    (miso),
		.miso_oe (miso_oe),
		.lk      (lk)
	);

	assign lk.tx_word  = reply_r;
	assign lk.oe_allow = oe_allow_r;

	// ----------------------------------------
	// Select synchroniser
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ss_meta_r <= 1'b1;
			ss_sync_r <= 1'b1;
			ss_prev_r <= 1'b1;
		end
		else
		begin
			ss_meta_r <= ss_n;
			ss_sync_r <= ss_meta_r;
			ss_prev_r <= ss_sync_r;
		end
	end

	assign ss_rise = ss_sync_r & ~ss_prev_r;

	// ----------------------------------------
	// Wire mode strap capture
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wm_meta_r <= 1'b0;
			wm_sync_r <= 1'b0;
		end
		else
		begin
			wm_meta_r <= wire_mode;
			wm_sync_r <= wm_meta_r;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			cap_cnt_r <= esp_pkg::CAP_DELAY;
		else if (soft_reset_r)
			cap_cnt_r <= esp_pkg::CAP_DELAY;
		else if (cap_cnt_r != esp_pkg::CAP_DONE)
			cap_cnt_r <= cap_cnt_r - esp_pkg::CAP_LAST;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			four_wire_r <= 1'b0;
		else if (cap_cnt_r == esp_pkg::CAP_LAST)
			four_wire_r <= wm_sync_r;
	end

	// ----------------------------------------
	// Frame capture at select rise
	// ----------------------------------------
	assign overrun = ss_rise & hold_valid_r & ~buf_in_ready;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			hold_valid_r <= 1'b0;
			hold_r       <= '0;
		end
		else if (ss_rise && !(hold_valid_r && !buf_in_ready))
		begin
			hold_valid_r <= 1'b1;
			hold_r       <= {lk.rx_count == esp_pkg::FRAME_LEN, lk.rx_word};
		end
		else if (buf_in_ready)
			hold_valid_r <= 1'b0;
	end

	esp_buf #(
		.W (17)
	) u_buf (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (hold_valid_r),
		.in_ready  (buf_in_ready),
		.in_data   (hold_r),
		.out_valid (buf_out_valid),
		.out_ready (state_r != esp_pkg::ST_READ),
		.out_data  (buf_out)
	);

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	assign pop  = buf_out_valid & (state_r != esp_pkg::ST_READ);
	assign f    = buf_out[15:0];
	assign addr = f[14:1];

	always_comb
	begin
		good    = buf_out[16] & ~(^f);
		bad     = pop & ~good;
		is_cmd  = pop & good & (state_r == esp_pkg::ST_CMD);
		is_data = pop & good & (state_r == esp_pkg::ST_DATA);
		nop     = is_cmd & (f == esp_pkg::WORD_ZERO);
		clr     = is_cmd & f[esp_pkg::BIT_RW] & (addr == esp_pkg::ADDR_CLR_ERR);
		wrong   = is_cmd & ((f[esp_pkg::BIT_RW] & (addr == esp_pkg::ADDR_SOFT_RST))
			| (~f[esp_pkg::BIT_RW] & (addr == esp_pkg::ADDR_CLR_ERR)));
		rd      = is_cmd & f[esp_pkg::BIT_RW] & ~clr & ~wrong;
		wr_cmd  = is_cmd & ~f[esp_pkg::BIT_RW] & ~nop & ~wrong;
	end

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			esp_pkg::ST_CMD:
			begin
				if (rd)
					state_nxt = esp_pkg::ST_READ;
				else if (wr_cmd)
					state_nxt = esp_pkg::ST_DATA;
			end
			esp_pkg::ST_DATA:
			begin
				if (pop)
					state_nxt = esp_pkg::ST_CMD;
			end
			esp_pkg::ST_READ:
				state_nxt = esp_pkg::ST_CMD;
			default:
				state_nxt = esp_pkg::ST_CMD;
		endcase
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			state_r <= esp_pkg::ST_CMD;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			cmd_addr_r <= esp_pkg::ADDR_NOP;
		else if (is_cmd)
			cmd_addr_r <= addr;
	end

	// ----------------------------------------
	// Sticky error flag, set wins over clear
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			ef_r <= 1'b0;
		else
			ef_r <= bad | wrong | overrun | (ef_r & ~clr);
	end

	// ----------------------------------------
	// Register access requests
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			reg_req_r    <= 1'b0;
			reg_write_r  <= 1'b0;
			reg_addr_r   <= esp_pkg::ADDR_NOP;
			reg_wdata_r  <= esp_pkg::DATA_ZERO;
			soft_reset_r <= 1'b0;
		end
		else
		begin
			reg_req_r    <= rd | is_data;
			reg_write_r  <= is_data;
			soft_reset_r <= is_data & (cmd_addr_r == esp_pkg::ADDR_SOFT_RST);
			if (rd)
				reg_addr_r <= addr;
			else if (is_data)
				reg_addr_r <= cmd_addr_r;
			if (is_data)
				reg_wdata_r <= f[15:2];
		end
	end

	// ----------------------------------------
	// Reply for the next frame
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rd_pend_r <= 1'b0;
		else if (state_r == esp_pkg::ST_READ)
			rd_pend_r <= 1'b1;
		else if (pop)
			rd_pend_r <= 1'b0;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			reply_r    <= esp_pkg::WORD_ZERO;
			oe_allow_r <= 1'b0;
		end
		else
		begin
			oe_allow_r <= four_wire_r | rd_pend_r | (state_r == esp_pkg::ST_READ);
			if (state_r == esp_pkg::ST_READ)
				reply_r <= esp_pkg::esp_reply(reg_rdata, ef_r);
			else if (bad || wrong)
				reply_r <= esp_pkg::esp_reply(esp_pkg::DATA_ZERO, 1'b1);
			else if (clr)
				reply_r <= esp_pkg::WORD_ZERO;
			else if (is_data)
				reply_r <= esp_pkg::esp_reply(f[15:2], ef_r);
			else if (nop || wr_cmd)
				reply_r <= esp_pkg::esp_reply(esp_pkg::DATA_ZERO, ef_r);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_req             = reg_req_r;
	assign reg_write           = reg_write_r;
	assign reg_addr            = reg_addr_r;
	assign reg_wdata           = reg_wdata_r;
	assign soft_reset          = soft_reset_r;
	assign transfer_error_flag = ef_r;
	assign four_wire_mode      = four_wire_r;
endmodule

// [testbench/esp_host.sv]
// Serial bus master model driving the encoder port
`timescale 1ns/1ns
module esp_host (
	// Serial pins
	output logic      sck,
	output logic      ss_n,
	output logic      mosi,
	input  wire logic miso,
	input  wire logic miso_oe
);
	logic oe_seen;

	initial
	begin
		sck = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b0;
		oe_seen = 1'b0;
	end

	// One frame of n clocks; sel low keeps select high
	task automatic xfer(input logic [15:0] tx, input int n, input logic sel,
		output logic [15:0] rx);
		rx = 16'h0000;
		oe_seen = 1'b0;
		ss_n = ~sel;
		#100;
		for (int i = 0; i < n; i++)
		begin
			sck = 1'b1;
			mosi = tx[15 - i % 16];
			#80;
			sck = 1'b0;
			rx = {rx[14:0], miso_oe ? miso : 1'b1};
			oe_seen = oe_seen | miso_oe;
			#80;
		end
		#40;
		ss_n = 1'b1;
		mosi = ~mosi;
		#400;
	endtask
endmodule

// [testbench/esp_port_asserts.sv]
// Concurrent checks on the encoder serial port pins
`timescale 1ns/1ns
module esp_port_asserts (
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// Serial pins
	input wire logic        sck,
	input wire logic        ss_n,
	input wire logic        miso,
	input wire logic        miso_oe,
	// Register access and status
	input wire logic        reg_req,
	input wire logic        reg_write,
	input wire logic [13:0] reg_addr,
	input wire logic        soft_reset,
	input wire logic        transfer_error_flag,
	input wire logic        four_wire_mode
);
	logic [3:0] since_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// ----------------------------------------
	// Cycles since reset or soft reset
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			since_r <= 4'h0;
		else if (soft_reset)
			since_r <= 4'h0;
		else if (since_r != 4'hF)
			since_r <= since_r + 4'h1;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	idle_oe_a: assert property (ss_n |-> !miso_oe)
		else $error("miso enable high while deselected");
	idle_miso_a: assert property (ss_n |-> !miso)
		else $error("miso not low while deselected");
	miso_edge_a: assert property (!ss_n && !$past(ss_n) && $changed(miso) |-> $rose(sck))
		else $error("miso moved without a serial clock rise");
	oe_four_a: assert property (four_wire_mode && !ss_n && $rose(sck) |=> miso_oe)
		else $error("miso not driven in four-wire frame");
	req_pulse_a: assert property (reg_req |=> !reg_req)
		else $error("register request longer than one cycle");
	req_idle_a: assert property (reg_req |-> ss_n)
		else $error("register request during a frame");
	rst_addr_a: assert property (soft_reset |-> reg_addr == esp_pkg::ADDR_SOFT_RST)
		else $error("soft reset without its address");
	mode_hold_a: assert property ($changed(four_wire_mode) |-> since_r < 4'h6)
		else $error("wire mode changed outside capture");

	wr_c: cover property (reg_req && reg_write);
	srst_c: cover property (soft_reset);
	err_c: cover property ($rose(transfer_error_flag));
endmodule

bind esp_port esp_port_asserts esp_port_asserts_inst (
	.clk(clk), .resetn(resetn), .sck(sck), .ss_n(ss_n), .miso(miso),
	.miso_oe(miso_oe), .reg_req(reg_req), .reg_write(reg_write),
	.reg_addr(reg_addr), .soft_reset(soft_reset),
	.transfer_error_flag(transfer_error_flag), .four_wire_mode(four_wire_mode)
);

// [testbench/esp_port_tb_top.sv]
// Self-checking bench for the encoder serial port
`timescale 1ns/1ns
module esp_port_tb_top;
	logic        clk;
	logic        resetn;
	logic        sck;
	logic        ss_n;
	logic        mosi;
	logic        miso;
	logic        miso_oe;
	logic        wire_mode;
	logic        reg_req;
	logic        reg_write;
	logic [13:0] reg_addr;
	logic [13:0] reg_wdata;
	logic [13:0] reg_rdata;
	logic        soft_reset;
	logic        flag;
	logic        four_wire_mode;
	logic [13:0] wr_seen;
	logic [13:0] wa_seen;
	logic [15:0] rx;
	logic [15:0] bad_tx [4];
	int          bad_n [4] = '{16, 15, 17, 16};
	int          miscompares;
	int          samples_checked;

	esp_port esp_port_inst (
		.clk(clk), .resetn(resetn), .sck(sck), .ss_n(ss_n), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe), .wire_mode(wire_mode),
		.reg_req(reg_req), .reg_write(reg_write), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .soft_reset(soft_reset),
		.transfer_error_flag(flag), .four_wire_mode(four_wire_mode)
	);
	esp_host esp_host_inst (
		.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe)
	);

	// Register stand-in: reads return the inverted address
	assign reg_rdata = ~reg_addr;

	always @(posedge clk)
	begin
		if (reg_req && reg_write)
		begin
			wr_seen <= reg_wdata;
			wa_seen <= reg_addr;
		end
	end

	function automatic logic [15:0] mk(input logic [14:0] u);
		mk = {u, ^u};
	endfunction

	task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic xf(input logic [15:0] tx, input int n = 16, input logic sel = 1'b1);
		@(posedge clk);
		#1;
		esp_host_inst.xfer(tx, n, sel, rx);
	endtask

	task automatic results;
		$display("checked %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial
	begin
		#300000;
		miscompares++;
		results();
	end

	initial
	begin
		resetn = 1'b0;
		wire_mode = 1'b1;
		wr_seen = 14'h0000;
		wa_seen = 14'h0000;
		miscompares = 0;
		samples_checked = 0;
		bad_tx = '{16'h0001, 16'h0000, 16'h0000, mk({1'b0, esp_pkg::ADDR_CLR_ERR})};
		repeat (10) @(posedge clk);
		#1 resetn = 1'b1;
		repeat (5) @(posedge clk);
		chk("four_wire_mode", {15'h0000, four_wire_mode}, 16'h0001);
		xf(16'h0000);
		xf(16'h0000);
		chk("nop reply", rx, 16'h0000);
		xf(mk({1'b1, 14'h0123}));
		xf(16'h0000);
		chk("read reply", rx, mk({~14'h0123, 1'b0}));
		xf(mk({1'b0, 14'h0055}));
		xf(mk({14'h2AAA, 1'b0}));
		xf(16'h0000);
		chk("write echo", rx, mk({14'h2AAA, 1'b0}));
		chk("write data", {2'h0, wr_seen}, 16'h2AAA);
		chk("write address", {2'h0, wa_seen}, 16'h0055);
		// Parity, short, long and wrong command frames
		for (int k = 0; k < 4; k++)
		begin
			xf(bad_tx[k], bad_n[k]);
			chk("flag set", {15'h0000, flag}, 16'h0001);
			xf(16'h0000);
			chk("error reply", rx, mk({14'h0000, 1'b1}));
			chk("flag sticky", {15'h0000, flag}, 16'h0001);
			xf(mk({1'b1, esp_pkg::ADDR_CLR_ERR}));
			chk("flag cleared", {15'h0000, flag}, 16'h0000);
			xf(16'h0000);
			chk("clear reply", rx, 16'h0000);
		end
		xf(16'hFFFF, 16, 1'b0);
		xf(16'h0000);
		chk("idle clocks", {rx[15:1], flag}, 16'h0000);
		wire_mode = 1'b0;
		repeat (10) @(posedge clk);
		chk("mode held", {15'h0000, four_wire_mode}, 16'h0001);
		xf(mk({1'b0, esp_pkg::ADDR_SOFT_RST}));
		xf(mk({14'h0000, 1'b0}));
		chk("mode recaptured", {15'h0000, four_wire_mode}, 16'h0000);
		xf(16'h0000);
		chk("three-wire quiet", {15'h0000, esp_host_inst.oe_seen}, 16'h0000);
		xf(mk({1'b1, 14'h0123}));
		xf(16'h0000);
		chk("three-wire drive", {15'h0000, esp_host_inst.oe_seen}, 16'h0001);
		chk("three-wire reply", rx, mk({~14'h0123, 1'b0}));
		results();
	end
endmodule
